// *** hw/erk_pkg.sv ***
// Package for the egress rewriter lookup key builder.
// Assumes one core clock; registers reached over classic Wishbone.
package erk_pkg;

	// Register byte offsets
	localparam logic [7:0] ERK_REG_RAM_INIT  = 8'h00;
	localparam logic [7:0] ERK_REG_LU_CTRL   = 8'h04;
	localparam logic [7:0] ERK_REG_DROP_PRECEDENCE_MAP    = 8'h08;
	localparam logic [7:0] ERK_REG_STATUS    = 8'h0C;
	localparam logic [7:0] ERK_REG_PORT_BASE = 8'h40;

	// Field positions
	localparam int ERK_BIT_CFG_RAM_ACCESS_ENABLE   = 0;
	localparam int ERK_BIT_RAM_INIT  = 1;
	localparam int ERK_BIT_LU_ENA    = 0;
	localparam int ERK_BIT_BY_RLEG   = 1;
	localparam int ERK_BIT_BY_ROUTE_FORWARD_FLAG = 2;
	localparam int ERK_BIT_SVC_ENA   = 8;

	// Geometry
	localparam int ERK_NUM_PORTS  = 16;
	localparam int ERK_PORT_W     = 6;
	localparam int ERK_CFGP_W     = 4;
	localparam int ERK_RAM_WORDS  = 64;
	localparam int ERK_RAM_AW     = 6;
	localparam int ERK_DP_W       = 2;

	// Frame expansion budget
	localparam logic [6:0] ERK_MAX_PUSH_BYTES = 7'h3C;
	localparam logic [6:0] ERK_PREAMBLE_BYTES = 7'h08;

	// Key constants
	localparam logic [9:0] ERK_VSI_ROUTED = 10'h3FF;
	localparam logic       ERK_TYPE_INGRESS_SERVICE_INDEX  = 1'h0;
	localparam logic       ERK_TYPE_VID   = 1'h1;

	// Destination mode encodings
	typedef enum logic [1:0] {
		ERK_DST_BRIDGE = 2'b00,
		ERK_DST_UC_RT  = 2'b01,
		ERK_DST_MC_RT  = 2'b10,
		ERK_DST_OTHER  = 2'b11
	} erk_destination_mode_t;

	// Per-frame header fields
	typedef struct packed {
		logic [ERK_CFGP_W-1:0] cfg_port;
		logic                  to_cpu;
		logic                  svc_key_ena;
		erk_destination_mode_t         destination_mode;
		logic                  route_forward_flag;
		logic [11:0]           general_index;
		logic                  general_index_mode;
		logic                  protection_active;
		logic [2:0]            cos_id;
		logic [ERK_DP_W-1:0]   drop_prec;
		logic [11:0]           svc_idx;
		logic [11:0]           tag_vid;
		logic [11:0]           egress_router_leg;
		logic [6:0]            push_bytes;
	} erk_hdr_t;

	// Built lookup key
	typedef struct packed {
		logic                  key_type;
		logic [ERK_PORT_W-1:0] logical_egress_port;
		logic                  protection_active;
		logic [9:0]            virtual_switch_instance;
		logic [2:0]            cos_id;
		logic                  color;
		logic                  svc_frame;
		logic [11:0]           idx_or_vid;
	} erk_key_t;

	// Per-frame decision
	typedef struct packed {
		logic                  lookup;
		logic                  modify;
		logic                  use_action;
		logic                  push_ok;
		logic [ERK_PORT_W-1:0] default_sel;
	} erk_dec_t;

endpackage

// *** hw/erk_ram_init.sv ***
// RAM-based configuration initializer: walks all words to zero.
// Assumes trigger comes from the register file on the same clock.
`timescale 1ns/1ns
module erk_ram_init
	import erk_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	input  wire logic                  i_start,
	output logic                       o_busy,
	output logic                       o_done,
	output logic                       o_wr,
	output logic [ERK_RAM_AW-1:0]      o_addr
);

	typedef enum logic [0:0] {
		ERK_INIT_IDLE = 1'b0,
		ERK_INIT_RUN  = 1'b1
	} erk_init_state_t;

	erk_init_state_t       state, next_state;
	logic [ERK_RAM_AW-1:0] addr, next_addr;
	logic                  done, next_done;

	// Next-state walk over every word
	always_comb begin
		next_state = state;
		next_addr  = addr;
		next_done  = 1'b0;
		unique case (state)
			ERK_INIT_IDLE: begin
				if (i_start) begin
					next_state = ERK_INIT_RUN;
					next_addr  = '0;
				end
			end
			ERK_INIT_RUN: begin
				next_addr = addr + 1'b1;
				if (addr == ERK_RAM_AW'(ERK_RAM_WORDS - 1)) begin
					next_state = ERK_INIT_IDLE;
					next_done  = 1'b1;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= ERK_INIT_IDLE;
			addr  <= '0;
			done  <= 1'b0;
		end else begin
			state <= next_state;
			addr  <= next_addr;
			done  <= next_done;
		end
	end

	assign o_busy = (state == ERK_INIT_RUN);
	assign o_done = done;
	assign o_wr   = (state == ERK_INIT_RUN);
	assign o_addr = addr;

endmodule // erk_ram_init

// *** hw/erk_key_build.sv ***
// Combinational key former for the egress match table lookup.
// Assumes per-port settings are already selected for the frame.
`timescale 1ns/1ns
module erk_key_build
	import erk_pkg::*;
(
	input  wire erk_hdr_t              i_hdr,
	input  wire logic                  i_by_rleg,
	input  wire logic                  i_by_route_forward_flag,
	input  wire logic [ERK_PORT_W-1:0] i_lport,
	input  wire logic                  i_svc_ena,
	input  wire logic                  i_color,
	output erk_key_t                   o_key
);

	logic rleg_hit;
	logic rtfwd_hit;
	logic vid_key;

	// Routing conditions and key type choice
	always_comb begin
		rleg_hit  = i_by_rleg && (i_hdr.destination_mode == ERK_DST_UC_RT ||
		            i_hdr.destination_mode == ERK_DST_MC_RT);
		rtfwd_hit = i_by_route_forward_flag && i_hdr.route_forward_flag;
		vid_key   = !i_hdr.svc_key_ena || rleg_hit || rtfwd_hit;
	end

	// Field forming
	always_comb begin
		o_key.key_type    = vid_key ? ERK_TYPE_VID : ERK_TYPE_INGRESS_SERVICE_INDEX;
		o_key.logical_egress_port    = i_lport;
		o_key.protection_active = i_hdr.protection_active;
		o_key.virtual_switch_instance = i_hdr.general_index_mode ? i_hdr.general_index[9:0] : '0;
		if (rleg_hit || rtfwd_hit)
			o_key.virtual_switch_instance = ERK_VSI_ROUTED;
		o_key.cos_id    = i_svc_ena ? i_hdr.cos_id : '0;
		o_key.color     = i_color;
		o_key.svc_frame = i_svc_ena && (i_hdr.svc_idx != '0);
		if (!vid_key) begin
			o_key.idx_or_vid = i_svc_ena ? i_hdr.svc_idx : '0;
		end else if (rleg_hit) begin
			o_key.idx_or_vid = i_hdr.egress_router_leg;
		end else if (rtfwd_hit) begin
			o_key.idx_or_vid = i_hdr.general_index;
		end else begin
			o_key.idx_or_vid = i_hdr.tag_vid;
		end
	end

endmodule // erk_key_build

// *** hw/erk_top.sv ***
// Egress rewriter lookup key builder top: Wishbone registers,
// RAM initialization and the per-frame key and decision pipeline.
// Assumes header strobes come from logic on the same core clock.
`timescale 1ns/1ns
module erk_top
	import erk_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	input  wire logic                  i_wb_cyc,
	input  wire logic                  i_wb_stb,
	input  wire logic                  i_wb_we,
	input  wire logic [7:0]            i_wb_adr,
	input  wire logic [3:0]            i_wb_sel,
	input  wire logic [31:0]           i_wb_dat,
	output logic      [31:0]           o_wb_dat,
	output logic                       o_wb_ack,
	input  wire logic                  i_hdr_valid,
	input  wire erk_hdr_t              i_hdr,
	output logic                       o_key_valid,
	output erk_key_t                   o_key,
	output erk_dec_t                   o_dec,
	output logic                       o_ram_wr,
	output logic      [ERK_RAM_AW-1:0] o_ram_addr
);

	logic                  cfg_ram_access_enable, next_cfg_ram_access_enable;
	logic                  init_trig, next_init_trig;
	logic                  lu_ena, next_lu_ena;
	logic                  by_rleg, next_by_rleg;
	logic                  by_route_forward_flag, next_by_route_forward_flag;
	logic [3:0]            drop_precedence_map, next_drop_precedence_map;
	logic [ERK_PORT_W-1:0] lport_map [ERK_NUM_PORTS];
	logic [ERK_PORT_W-1:0] next_lport_map [ERK_NUM_PORTS];
	logic [ERK_NUM_PORTS-1:0] svc_ena, next_svc_ena;
	logic                  ack, next_ack;
	logic [31:0]           rdat, next_rdat;
	logic                  init_start;
	logic                  init_busy;
	logic                  init_done;
	logic                  wr_req;
	logic                  rd_req;
	logic                  port_hit;
	logic [ERK_CFGP_W-1:0] port_idx;
	logic [7:0]            port_off;

	// Bus decode; a classic cycle is answered one cycle after the strobe
	assign wr_req   = i_wb_cyc && i_wb_stb && i_wb_we && !ack;
	assign rd_req   = i_wb_cyc && i_wb_stb && !i_wb_we && !ack;
	assign port_off = i_wb_adr - ERK_REG_PORT_BASE;
	assign port_hit = (i_wb_adr >= ERK_REG_PORT_BASE) &&
	                  (port_off[7:2] < 6'(ERK_NUM_PORTS)) &&
	                  (port_off[1:0] == 2'h0);
	assign port_idx = port_off[ERK_CFGP_W+1:2];

	// Control register next values
	always_comb begin
		next_cfg_ram_access_enable   = cfg_ram_access_enable;
		next_init_trig = init_trig;
		next_lu_ena    = lu_ena;
		next_by_rleg   = by_rleg;
		next_by_route_forward_flag = by_route_forward_flag;
		next_drop_precedence_map    = drop_precedence_map;
		next_lport_map = lport_map;
		next_svc_ena   = svc_ena;
		init_start     = 1'b0;
		// Clear on completion first so a fresh write still lands
		if (init_done)
			next_init_trig = 1'b0;
		if (wr_req && i_wb_sel[0]) begin
			unique case (1'b1)
				(i_wb_adr == ERK_REG_RAM_INIT): begin
					next_cfg_ram_access_enable = i_wb_dat[ERK_BIT_CFG_RAM_ACCESS_ENABLE];
					// Trigger only counts with RAM access enabled
					if (i_wb_dat[ERK_BIT_RAM_INIT] && !init_busy &&
					    i_wb_dat[ERK_BIT_CFG_RAM_ACCESS_ENABLE]) begin
						next_init_trig = 1'b1;
						init_start     = 1'b1;
					end
				end
				(i_wb_adr == ERK_REG_LU_CTRL): begin
					next_lu_ena    = i_wb_dat[ERK_BIT_LU_ENA];
					next_by_rleg   = i_wb_dat[ERK_BIT_BY_RLEG];
					next_by_route_forward_flag = i_wb_dat[ERK_BIT_BY_ROUTE_FORWARD_FLAG];
				end
				(i_wb_adr == ERK_REG_DROP_PRECEDENCE_MAP): begin
					next_drop_precedence_map = i_wb_dat[3:0];
				end
				port_hit: begin
					next_lport_map[port_idx] = i_wb_dat[ERK_PORT_W-1:0];
					next_svc_ena[port_idx]   = i_wb_dat[ERK_BIT_SVC_ENA];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data mux; unmapped addresses read zero
	always_comb begin
		next_ack  = (wr_req || rd_req);
		next_rdat = rdat;
		if (rd_req) begin
			next_rdat = '0;
			if (i_wb_adr == ERK_REG_RAM_INIT) begin
				next_rdat[ERK_BIT_CFG_RAM_ACCESS_ENABLE]  = cfg_ram_access_enable;
				next_rdat[ERK_BIT_RAM_INIT] = init_trig;
			end else if (i_wb_adr == ERK_REG_LU_CTRL) begin
				next_rdat[ERK_BIT_LU_ENA]    = lu_ena;
				next_rdat[ERK_BIT_BY_RLEG]   = by_rleg;
				next_rdat[ERK_BIT_BY_ROUTE_FORWARD_FLAG] = by_route_forward_flag;
			end else if (i_wb_adr == ERK_REG_DROP_PRECEDENCE_MAP) begin
				next_rdat[3:0] = drop_precedence_map;
			end else if (i_wb_adr == ERK_REG_STATUS) begin
				next_rdat[0] = init_busy;
			end else if (port_hit) begin
				next_rdat[ERK_PORT_W-1:0] = lport_map[port_idx];
				next_rdat[ERK_BIT_SVC_ENA] = svc_ena[port_idx];
			end
		end
	end

	// Register file flops; port map resets to identity
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_ram_access_enable   <= 1'b0;
			init_trig <= 1'b0;
			lu_ena    <= 1'b0;
			by_rleg   <= 1'b0;
			by_route_forward_flag <= 1'b0;
			drop_precedence_map    <= 4'h0;
			svc_ena   <= '0;
			ack       <= 1'b0;
			rdat      <= 32'h0000_0000;
		end else begin
			cfg_ram_access_enable   <= next_cfg_ram_access_enable;
			init_trig <= next_init_trig;
			lu_ena    <= next_lu_ena;
			by_rleg   <= next_by_rleg;
			by_route_forward_flag <= next_by_route_forward_flag;
			drop_precedence_map    <= next_drop_precedence_map;
			svc_ena   <= next_svc_ena;
			ack       <= next_ack;
			rdat      <= next_rdat;
		end
	end

	// Per-port map flops, identity after reset
	genvar gp;
	generate
		for (gp = 0; gp < ERK_NUM_PORTS; gp++) begin : g_port
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn)
					lport_map[gp] <= ERK_PORT_W'(gp);
				else
					lport_map[gp] <= next_lport_map[gp];
			end
		end
	endgenerate

	assign o_wb_ack = ack;
	assign o_wb_dat = rdat;

	// RAM initialization walker
	erk_ram_init u_init (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_start (init_start),
		.o_busy  (init_busy),
		.o_done  (init_done),
		.o_wr    (o_ram_wr),
		.o_addr  (o_ram_addr)
	);

	// Per-frame key forming
	erk_key_t              key_c;
	logic [ERK_PORT_W-1:0] lport_c;
	logic                  svc_c;
	logic                  color_c;
	erk_dec_t              dec_c;

	assign lport_c = lport_map[i_hdr.cfg_port];
	assign svc_c   = svc_ena[i_hdr.cfg_port];
	assign color_c = drop_precedence_map[i_hdr.drop_prec];

	erk_key_build u_key (
		.i_hdr       (i_hdr),
		.i_by_rleg   (by_rleg),
		.i_by_route_forward_flag (by_route_forward_flag),
		.i_lport     (lport_c),
		.i_svc_ena   (svc_c),
		.i_color     (color_c),
		.o_key       (key_c)
	);

	// Decision; init in progress also blocks the lookup
	always_comb begin
		dec_c.lookup      = lu_ena && !i_hdr.to_cpu && !init_busy;
		dec_c.modify      = !i_hdr.to_cpu;
		dec_c.use_action  = dec_c.lookup;
		// Budget already includes the preamble bytes
		dec_c.push_ok     = (i_hdr.push_bytes <= ERK_MAX_PUSH_BYTES)
		                    && (i_hdr.push_bytes >= ERK_PREAMBLE_BYTES);
		dec_c.default_sel = lport_c;
	end

	// Output stage registered one cycle after the header strobe
	logic     kv, next_kv;
	erk_key_t key_q, next_key_q;
	erk_dec_t dec_q, next_dec_q;

	always_comb begin
		next_kv    = i_hdr_valid;
		next_key_q = key_q;
		next_dec_q = dec_q;
		if (i_hdr_valid) begin
			next_key_q = key_c;
			next_dec_q = dec_c;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			kv    <= 1'b0;
			key_q <= '0;
			dec_q <= '0;
		end else begin
			kv    <= next_kv;
			key_q <= next_key_q;
			dec_q <= next_dec_q;
		end
	end

	assign o_key_valid = kv;
	assign o_key       = key_q;
	assign o_dec       = dec_q;

endmodule // erk_top

// *** dv/erk_monitor.sv ***
// Checker for the key builder top: bus, frame and init timing.
// Bound to erk_top; sees its ports only, one core clock.
`timescale 1ns/1ns
module erk_monitor
	import erk_pkg::*;
(
	input wire logic     i_clk,
	input wire logic     i_rstn,
	input wire logic     i_wb_cyc,
	input wire logic     i_wb_stb,
	input wire logic     o_wb_ack,
	input wire logic     i_hdr_valid,
	input wire erk_hdr_t i_hdr,
	input wire logic     o_key_valid,
	input wire erk_key_t o_key,
	input wire erk_dec_t o_dec,
	input wire logic     o_ram_wr,
	input wire logic [ERK_RAM_AW-1:0] o_ram_addr
);
	logic [7:0] walk_cnt;
	logic [7:0] next_walk_cnt;

	// Length of the current init walk
	always_comb next_walk_cnt = o_ram_wr ? walk_cnt + 8'h01 : 8'h00;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) walk_cnt <= 8'h00;
		else walk_cnt <= next_walk_cnt;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// Bus answers in one cycle, pulse only
	ack_next_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus ack missing");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("bus ack held");
	// Key follows each header by one cycle
	key_next_a: assert property (i_hdr_valid |=> o_key_valid)
		else $error("key valid missing");
	key_only_a: assert property (!i_hdr_valid |=> !o_key_valid)
		else $error("key valid without header");
	cpu_plain_a: assert property (i_hdr_valid && i_hdr.to_cpu |=>
		!o_dec.lookup && !o_dec.modify) else $error("cpu frame touched");
	action_off_a: assert property (o_key_valid && !o_dec.lookup |->
		!o_dec.use_action) else $error("action used without lookup");
	vid_key_a: assert property (i_hdr_valid && !i_hdr.svc_key_ena |=>
		o_key.key_type == ERK_TYPE_VID) else $error("key type wrong");
	prot_copy_a: assert property (i_hdr_valid |=>
		o_key.protection_active == $past(i_hdr.protection_active))
		else $error("protection bit wrong");
	svc_frame_a: assert property (o_key_valid && o_key.svc_frame |->
		$past(i_hdr.svc_idx) != 12'h000) else $error("service frame wrong");
	push_ok_a: assert property (i_hdr_valid |=> o_dec.push_ok ==
		($past(i_hdr.push_bytes) >= ERK_PREAMBLE_BYTES &&
		$past(i_hdr.push_bytes) <= ERK_MAX_PUSH_BYTES))
		else $error("push budget wrong");
	walk_len_a: assert property ($fell(o_ram_wr) |-> walk_cnt == 8'h40)
		else $error("init walk length wrong");
	// Walk must touch every word once, in order from zero
	walk_addr_a: assert property (o_ram_wr && $past(o_ram_wr) |->
		o_ram_addr == $past(o_ram_addr) + 6'h01)
		else $error("init walk address wrong");
	walk_start_a: assert property ($rose(o_ram_wr) |->
		o_ram_addr == 6'h00) else $error("init walk start wrong");

	cover property (o_key_valid && o_dec.lookup);
	cover property (o_key_valid && o_key.key_type == ERK_TYPE_INGRESS_SERVICE_INDEX);
	cover property ($fell(o_ram_wr));
endmodule // erk_monitor

bind erk_top erk_monitor u_mon (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_hdr_valid(i_hdr_valid),
	.i_hdr(i_hdr), .o_key_valid(o_key_valid), .o_key(o_key),
	.o_dec(o_dec), .o_ram_wr(o_ram_wr), .o_ram_addr(o_ram_addr)
);

// *** dv/erk_hdr_src.sv ***
// Header source standing in for the analyzer and queue system.
// Driven by the bench on the core clock; one header per request.
`timescale 1ns/1ns
module erk_hdr_src
	import erk_pkg::*;
(
	input  wire logic     i_clk,
	input  wire logic     i_send,
	input  wire erk_hdr_t i_hdr,
	output logic          o_valid,
	output erk_hdr_t      o_hdr
);
	initial begin
		o_valid = 1'b0;
		o_hdr = '0;
	end
	// Fields toggle outside valid so stale data never looks right
	always @(posedge i_clk) begin
		o_valid <= i_send;
		o_hdr <= i_send ? i_hdr : ~o_hdr;
	end
endmodule // erk_hdr_src

// *** dv/test_egress_rewriter_lookup_key_builder.sv ***
// Bench for erk_top: Wishbone master, header source, result queues.
// Assumes 20 MHz core clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module test_egress_rewriter_lookup_key_builder;
	import erk_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, send = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, hvalid, kvalid, ram_wr;
	logic [5:0]  ram_addr;
	erk_hdr_t    hin = '0, hdr;
	erk_key_t    key, key_q[$];
	erk_dec_t    dec, dec_q[$];
	logic [31:0] rd_q[$];
	logic [5:0]  pmap[16];
	logic        psvc[16];
	logic [3:0]  dpm = 4'h0;
	logic [2:0]  luc = 3'h0;
	logic [6:0]  pb[4] = '{7'h07, 7'h08, 7'h3C, 7'h3D};
	int          fail_count = 0;
	int          tests_run = 0;

	always #25 i_clk = ~i_clk;

	erk_top DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_hdr_valid(hvalid), .i_hdr(hdr), .o_key_valid(kvalid),
		.o_key(key), .o_dec(dec), .o_ram_wr(ram_wr), .o_ram_addr(ram_addr));
	erk_hdr_src u_src (.i_clk(i_clk), .i_send(send), .i_hdr(hin),
		.o_valid(hvalid), .o_hdr(hdr));

	// Expected key from header and mirrored settings
	function automatic erk_key_t exp_key(erk_hdr_t h);
		erk_key_t k;
		logic rl, rf, sv;
		rl = luc[ERK_BIT_BY_RLEG] &&
			(h.destination_mode == ERK_DST_UC_RT || h.destination_mode == ERK_DST_MC_RT);
		rf = luc[ERK_BIT_BY_ROUTE_FORWARD_FLAG] && h.route_forward_flag;
		sv = psvc[h.cfg_port];
		k.key_type = (!h.svc_key_ena || rl || rf) ? ERK_TYPE_VID
			: ERK_TYPE_INGRESS_SERVICE_INDEX;
		k.logical_egress_port = pmap[h.cfg_port];
		k.protection_active = h.protection_active;
		k.virtual_switch_instance = (rl || rf) ? ERK_VSI_ROUTED
			: (h.general_index_mode ? h.general_index[9:0] : 10'h000);
		k.cos_id = sv ? h.cos_id : 3'h0;
		k.color = dpm[h.drop_prec];
		k.svc_frame = sv && (h.svc_idx != 12'h000);
		if (k.key_type == ERK_TYPE_INGRESS_SERVICE_INDEX) k.idx_or_vid = sv ? h.svc_idx : 12'h000;
		else k.idx_or_vid = rl ? h.egress_router_leg : (rf ? h.general_index : h.tag_vid);
		return k;
	endfunction

	// Expected decision; busy never overlaps headers here
	function automatic erk_dec_t exp_dec(erk_hdr_t h);
		erk_dec_t d;
		d.lookup = luc[ERK_BIT_LU_ENA] && !h.to_cpu;
		d.modify = !h.to_cpu;
		d.use_action = d.lookup;
		d.push_ok = h.push_bytes >= ERK_PREAMBLE_BYTES &&
			h.push_bytes <= ERK_MAX_PUSH_BYTES;
		d.default_sel = pmap[h.cfg_port];
		return d;
	endfunction

	task automatic miss(input string what);
		fail_count++;
		$display("CHECK FAILED %s exp 1 got 0", what);
	endtask
	task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED read data exp %h got %h", e, g);
		end
	endtask
	task automatic cmp_key(input erk_key_t e, input erk_key_t g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED key exp %h got %h", e, g);
		end
	endtask
	task automatic cmp_dec(input erk_dec_t e, input erk_dec_t g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED decision exp %h got %h", e, g);
		end
	endtask

	// Classic cycle: hold request until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) miss("bus ack");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask

	// Back-to-back random headers, boundary push counts half the time
	task automatic burst(input int n);
		erk_hdr_t h;
		logic [95:0] r;
		for (int i = 0; i < n; i++) begin
			r = {$urandom, $urandom, $urandom};
			h = r[$bits(erk_hdr_t)-1:0];
			h.to_cpu = ($urandom_range(7) == 0);
			if ($urandom_range(1) == 1) h.push_bytes = pb[$urandom_range(3)];
			key_q.push_back(exp_key(h));
			dec_q.push_back(exp_dec(h));
			@(posedge i_clk);
			send <= 1'b1;
			hin <= h;
		end
		@(posedge i_clk);
		send <= 1'b0;
	endtask

	// Results are matched against the oldest note
	always @(posedge i_clk) begin
		if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
			cmp_reg(rd_q.pop_front(), rdat);
		if (kvalid === 1'b1 && key_q.size() > 0) begin
			cmp_key(key_q.pop_front(), key);
			cmp_dec(dec_q.pop_front(), dec);
		end
	end

	task automatic finish_test;
		$display("checks %0d failures %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Cuts a hang short well past the expected run length
	initial begin
		repeat (20000) @(posedge i_clk);
		miss("run time");
		finish_test;
	end

	initial begin
		int n, p;
		logic [31:0] v;
		void'($urandom(28));
		for (int i = 0; i < 16; i++) begin
			pmap[i] = 6'(i);
			psvc[i] = 1'b0;
		end
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		rd(ERK_REG_RAM_INIT, 32'h0);
		rd(ERK_REG_LU_CTRL, 32'h0);
		rd(ERK_REG_PORT_BASE + 8'h14, 32'h5);
		wb(1'b1, 8'h30, 32'hFFFFFFFF);
		rd(8'h30, 32'h0);
		wb(1'b1, ERK_REG_RAM_INIT, 32'h2);
		rd(ERK_REG_RAM_INIT, 32'h0);
		$display("test reset_and_refusal done");
		wb(1'b1, ERK_REG_RAM_INIT, 32'h1);
		wb(1'b1, ERK_REG_RAM_INIT, 32'h3);
		rd(ERK_REG_RAM_INIT, 32'h3);
		rd(ERK_REG_STATUS, 32'h1);
		n = 0;
		while (ram_wr !== 1'b0 && n < 200) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 200) miss("init end");
		rd(ERK_REG_RAM_INIT, 32'h1);
		rd(ERK_REG_STATUS, 32'h0);
		$display("test init done");
		// Configuration only after init; every lookup mode once
		for (int m = 0; m < 8; m++) begin
			luc = 3'(m);
			wb(1'b1, ERK_REG_LU_CTRL, 32'(m));
			v = $urandom;
			dpm = v[3:0];
			wb(1'b1, ERK_REG_DROP_PRECEDENCE_MAP, v);
			repeat (4) begin
				p = $urandom_range(15);
				v = $urandom;
				pmap[p] = v[5:0];
				psvc[p] = v[8];
				wb(1'b1, ERK_REG_PORT_BASE + 8'(p * 4), v);
				rd(ERK_REG_PORT_BASE + 8'(p * 4), v & 32'h13F);
			end
			rd(ERK_REG_LU_CTRL, 32'(m));
			burst(12);
		end
		repeat (4) @(posedge i_clk);
		if (key_q.size() != 0) miss("key count");
		$display("test mode_sweep done");
		finish_test;
	end
endmodule // test_egress_rewriter_lookup_key_builder
